// [design/bwl_burst_write.sv]
`timescale 1ns/1ps
// Contract
// - selects act only inside an accepted burst
// - each beat masked by its own selects
// - nibble selects low write [3:0], [7:4]
// - byte selects low write [8:0], [17:9]
// - both selects high: beat writes nothing
// - single select gates whole 9-bit beat
// - four selects map to four 9-bit lanes
// - all low writes 36 bits, high none
// - four beats follow on consecutive beat slots
module bwl_burst_write #(
    parameter logic [1:0] CONFIG = bwl_pkg::CFG_X18,
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // write address load
    input wire logic wr_load_n,
    input wire logic [ADDR_W-1:0] wr_addr,
    // write beat
    input wire logic [35:0] wr_data,
    input wire logic lane0_write_select_n,
    input wire logic lane1_write_select_n,
    input wire logic lane2_write_select_n,
    input wire logic lane3_write_select_n,
    input wire logic low_nibble_write_select_n,
    input wire logic high_nibble_write_select_n,
    // flow control
    input wire logic array_hold,
    output logic beat_ready,
    output logic burst_active,
    // readback of the array
    input wire logic [ADDR_W+1:0] rd_addr,
    output logic [35:0] rd_data
);
    localparam int LANE_W = (CONFIG == bwl_pkg::CFG_X8) ? bwl_pkg::NIBBLE_W : bwl_pkg::BYTE_W;
    localparam int LANES = (CONFIG == bwl_pkg::CFG_X9) ? 1 : ((CONFIG == bwl_pkg::CFG_X36) ? 4 : 2);
    localparam int DATA_W = LANES * LANE_W;
    localparam int WADDR_W = ADDR_W + bwl_pkg::BEAT_IDX_W;
    localparam int ENTRY_W = WADDR_W + DATA_W + LANES;

    // per-lane write enables from the sampled selects of one beat
    function automatic logic [3:0] lane_mask(input logic [3:0] sel_n, input logic [1:0] nib_n);
        logic [3:0] m;
        m = bwl_pkg::NO_LANES;
        case (CONFIG)
            bwl_pkg::CFG_X8: m = {2'h0, ~nib_n};
            bwl_pkg::CFG_X9: m = {3'h0, ~sel_n[0]};
            bwl_pkg::CFG_X18: m = {2'h0, ~sel_n[1:0]};
            bwl_pkg::CFG_X36: m = ~sel_n;
            default: m = bwl_pkg::NO_LANES;
        endcase
        return m;
    endfunction

    function automatic logic [1:0] beat_index(input bwl_pkg::bwl_state_e s);
        logic [1:0] b;
        b = bwl_pkg::BEAT_0;
        case (s)
            bwl_pkg::BWL_BEAT1: b = bwl_pkg::BEAT_1;
            bwl_pkg::BWL_BEAT2: b = bwl_pkg::BEAT_2;
            bwl_pkg::BWL_BEAT3: b = bwl_pkg::BEAT_3;
            default: b = bwl_pkg::BEAT_0;
        endcase
        return b;
    endfunction

    bwl_pkg::bwl_state_e state;
    bwl_pkg::bwl_state_e next_state;
    logic [ADDR_W-1:0] base_addr;
    logic load_take;
    logic push;
    logic pop;
    logic [3:0] beat_mask;
    logic [ENTRY_W-1:0] push_entry;
    logic [ENTRY_W-1:0] pop_entry;
    logic [ENTRY_W-1:0] buf_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [bwl_pkg::BUF_CNT_W-1:0] count;
    logic [bwl_pkg::BUF_CNT_W-1:0] next_count;
    logic [DATA_W-1:0] ram_rd;

    // a load is taken when no beat is still owed, or on the last beat
    assign load_take = !wr_load_n && beat_ready
        && (state == bwl_pkg::BWL_IDLE || state == bwl_pkg::BWL_BEAT3);
    // beats only count inside a burst; stray selects are dropped
    assign push = (state != bwl_pkg::BWL_IDLE) && beat_ready;
    assign pop = (count != bwl_pkg::BUF_EMPTY) && !array_hold;
    assign beat_mask = lane_mask({lane3_write_select_n, lane2_write_select_n,
        lane1_write_select_n, lane0_write_select_n},
        {high_nibble_write_select_n, low_nibble_write_select_n});
    assign push_entry = {base_addr, beat_index(state), wr_data[DATA_W-1:0], beat_mask[LANES-1:0]};
    assign pop_entry = buf_mem[rd_ptr];

    always_comb begin
        next_state = state;
        case (state)
            bwl_pkg::BWL_IDLE: if (load_take) next_state = bwl_pkg::BWL_BEAT0;
            bwl_pkg::BWL_BEAT0: if (push) next_state = bwl_pkg::BWL_BEAT1;
            bwl_pkg::BWL_BEAT1: if (push) next_state = bwl_pkg::BWL_BEAT2;
            bwl_pkg::BWL_BEAT2: if (push) next_state = bwl_pkg::BWL_BEAT3;
            bwl_pkg::BWL_BEAT3: begin
                if (push) begin
                    next_state = load_take ? bwl_pkg::BWL_BEAT0 : bwl_pkg::BWL_IDLE;
                end
            end
            default: next_state = bwl_pkg::BWL_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= bwl_pkg::BWL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burst_active <= 1'b0;
        end else begin
            burst_active <= (next_state != bwl_pkg::BWL_IDLE);
        end
    end

    // burst address held for all four beats
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            base_addr <= '0;
        end else if (load_take && (state == bwl_pkg::BWL_IDLE || push)) begin
            base_addr <= wr_addr;
        end
    end

    // two-entry buffer: a held array stalls the beats instead of losing one
    always_ff @(posedge clock) begin
        if (push) begin
            buf_mem[wr_ptr] <= push_entry;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
        end
    end

    always_comb begin
        next_count = count;
        case ({push, pop})
            2'h2: next_count = count + bwl_pkg::BUF_ONE;
            2'h1: next_count = count - bwl_pkg::BUF_ONE;
            default: next_count = count;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= bwl_pkg::BUF_EMPTY;
            beat_ready <= 1'b1;
        end else begin
            count <= next_count;
            beat_ready <= (next_count < bwl_pkg::BUF_DEPTH);
        end
    end

    bwl_lane_ram #(
        .LANES(LANES),
        .LANE_W(LANE_W),
        .AW(WADDR_W)
    ) u_ram (
        .clock(clock),
        .wr_en(pop),
        .wr_addr(pop_entry[ENTRY_W-1 -: WADDR_W]),
        .wr_lane_en(pop_entry[LANES-1:0]),
        .wr_data(pop_entry[LANES +: DATA_W]),
        .rd_addr(rd_addr[WADDR_W-1:0]),
        .rd_data(ram_rd)
    );

    // unused upper data bits read as zero
    if (DATA_W < 36) begin : g_pad
        assign rd_data = {{(36 - DATA_W){1'b0}}, ram_rd};
    end else begin : g_full
        assign rd_data = ram_rd;
    end

    // checks
    sequence s_three_beats;
        (state == bwl_pkg::BWL_BEAT0 && push) ##1 (state == bwl_pkg::BWL_BEAT1 && push)
            ##1 (state == bwl_pkg::BWL_BEAT2 && push);
    endsequence

    sequence s_load_idle;
        state == bwl_pkg::BWL_IDLE && load_take;
    endsequence

    // back-to-back burst: the next load rides on the last beat
    sequence s_load_chained;
        state == bwl_pkg::BWL_BEAT3 && load_take;
    endsequence

    sequence s_last_beat;
        state == bwl_pkg::BWL_BEAT3 && push && !load_take;
    endsequence

    chk_idle_no_push: assert property (@(posedge clock) disable iff (!rst_n)
        (state == bwl_pkg::BWL_IDLE) |=> (count <= $past(count)))
        else $error("beat taken outside a write burst");

    chk_load_first_beat: assert property (@(posedge clock) disable iff (!rst_n)
        s_load_idle |=> (state == bwl_pkg::BWL_BEAT0) && (base_addr == $past(wr_addr)))
        else $error("first beat slot does not follow the address load");

    chk_beat_run: assert property (@(posedge clock) disable iff (!rst_n)
        s_three_beats |=> (state == bwl_pkg::BWL_BEAT3) && burst_active)
        else $error("burst beats out of order");

    chk_beat_address: assert property (@(posedge clock) disable iff (!rst_n)
        push |-> push_entry[ENTRY_W-1 -: WADDR_W] == {base_addr, beat_index(state)})
        else $error("beat written to wrong burst address");

    chk_nibble_lanes: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X8) |->
        beat_mask[1:0] == {!high_nibble_write_select_n, !low_nibble_write_select_n})
        else $error("nibble lane enable mismatch");

    chk_none_high: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X18 && lane0_write_select_n && lane1_write_select_n)
        |-> push_entry[LANES-1:0] == '0)
        else $error("deselected beat would write");

    chk_wide_lanes: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X36 && !lane0_write_select_n && !lane1_write_select_n
        && !lane2_write_select_n && !lane3_write_select_n) |-> beat_mask == bwl_pkg::ALL_LANES)
        else $error("full word not enabled");

    chk_lane0_select: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG != bwl_pkg::CFG_X8) |-> beat_mask[0] == !lane0_write_select_n)
        else $error("lane 0 enable does not follow its select");

    chk_buffer_full: assert property (@(posedge clock) disable iff (!rst_n)
        (count == bwl_pkg::BUF_DEPTH) |-> !beat_ready && !push)
        else $error("buffer accepts beyond its depth");

    chk_held_stays: assert property (@(posedge clock) disable iff (!rst_n)
        (array_hold && !push) |=> count == $past(count))
        else $error("buffer drained while the array is held");

    // lane decode per configuration
    chk_x18_lanes: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X18) |->
        beat_mask[1:0] == {!lane1_write_select_n, !lane0_write_select_n})
        else $error("byte lane enable mismatch");

    chk_x36_lanes: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X36) |->
        beat_mask == ~{lane3_write_select_n, lane2_write_select_n, lane1_write_select_n, lane0_write_select_n})
        else $error("wide lane enable mismatch");

    // single select: a high select must leave the whole word alone
    chk_x9_nothing: assert property (@(posedge clock) disable iff (!rst_n)
        (push && CONFIG == bwl_pkg::CFG_X9 && lane0_write_select_n) |->
        push_entry[0] == 1'b0)
        else $error("deselected single lane would write");

    // burst sequencing
    chk_chain_load: assert property (@(posedge clock) disable iff (!rst_n)
        s_load_chained |=> (state == bwl_pkg::BWL_BEAT0) && (base_addr == $past(wr_addr)))
        else $error("chained load does not start a new burst");

    chk_last_beat: assert property (@(posedge clock) disable iff (!rst_n)
        s_last_beat |=> (state == bwl_pkg::BWL_IDLE) && !burst_active)
        else $error("burst does not end after its fourth beat");

    // a refused beat must leave the burst where it was
    chk_stalled_beat: assert property (@(posedge clock) disable iff (!rst_n)
        (state != bwl_pkg::BWL_IDLE && !beat_ready) |=> state == $past(state))
        else $error("burst moved on without taking its beat");

    // loads in mid-burst are refused, so the address holds
    chk_base_held: assert property (@(posedge clock) disable iff (!rst_n)
        (state == bwl_pkg::BWL_BEAT0 || state == bwl_pkg::BWL_BEAT1 || state == bwl_pkg::BWL_BEAT2)
        |=> base_addr == $past(base_addr))
        else $error("burst address changed in mid-burst");

    // buffer flow
    chk_count_bound: assert property (@(posedge clock) disable iff (!rst_n)
        count <= bwl_pkg::BUF_DEPTH)
        else $error("buffer count beyond its depth");

    chk_empty_ready: assert property (@(posedge clock) disable iff (!rst_n)
        (count == bwl_pkg::BUF_EMPTY) |-> beat_ready)
        else $error("empty buffer refuses a beat");

    // two beats in flight is the limit; a third waits
    chk_fill_stall: assert property (@(posedge clock) disable iff (!rst_n)
        (count == bwl_pkg::BUF_ONE && push && !pop) |=> !beat_ready && (count == bwl_pkg::BUF_DEPTH))
        else $error("full buffer still offers ready");
endmodule

// [design/bwl_lane_ram.sv]
`timescale 1ns/1ps
module bwl_lane_ram #(
    parameter int LANES = 2,
    parameter int LANE_W = 9,
    parameter int AW = 20
) (
    // clock
    input wire logic clock,
    // lane-masked write
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [LANES-1:0] wr_lane_en,
    input wire logic [LANES*LANE_W-1:0] wr_data,
    // registered readback
    input wire logic [AW-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data
);
    // one array per lane, so a deselected lane is never touched
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [2**AW];
        always_ff @(posedge clock) begin
            if (wr_en && wr_lane_en[g]) begin
                mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
            end
        end
        always_ff @(posedge clock) begin
            rd_data[g*LANE_W +: LANE_W] <= mem[rd_addr];
        end
    end
endmodule

// [design/bwl_pkg.sv]
package bwl_pkg;
    // lane configurations
    localparam logic [1:0] CFG_X8 = 2'h0;
    localparam logic [1:0] CFG_X9 = 2'h1;
    localparam logic [1:0] CFG_X18 = 2'h2;
    localparam logic [1:0] CFG_X36 = 2'h3;
    // lane widths
    localparam int NIBBLE_W = 4;
    localparam int BYTE_W = 9;
    localparam int MAX_LANES = 4;
    // burst of four beats
    localparam int BEAT_IDX_W = 2;
    localparam logic [1:0] BEAT_0 = 2'h0;
    localparam logic [1:0] BEAT_1 = 2'h1;
    localparam logic [1:0] BEAT_2 = 2'h2;
    localparam logic [1:0] BEAT_3 = 2'h3;
    // two-entry beat buffer
    localparam int BUF_CNT_W = 2;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_ONE = 2'h1;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam logic [3:0] ALL_LANES = 4'hF;

    typedef enum logic [4:0] {
        BWL_IDLE = 5'b00001,
        BWL_BEAT0 = 5'b00010,
        BWL_BEAT1 = 5'b00100,
        BWL_BEAT2 = 5'b01000,
        BWL_BEAT3 = 5'b10000
    } bwl_state_e;
endpackage

// [test/bwl_ctrl_model.sv]
`timescale 1ns/1ps
module bwl_ctrl_model (
    // clock
    input wire logic clock,
    // burst toward the device
    output logic wr_load_n,
    output logic [17:0] wr_addr,
    output logic [35:0] wr_data,
    output logic [3:0] sel_n,
    // handshake
    input wire logic beat_ready,
    output logic hang
);
    initial begin
        wr_load_n = 1'b1;
        wr_addr = 18'h0;
        wr_data = 36'h0;
        sel_n = 4'h0;
        hang = 1'b0;
    end
    // ready is looked at mid-cycle, the request stays put until an edge with ready high
    task automatic take();
        int n;
        n = 0;
        @(negedge clock);
        while (beat_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        if (n >= 200) hang <= 1'b1;
        @(posedge clock);
    endtask
    task automatic burst(input logic [17:0] a, input logic [143:0] d, input logic [15:0] s,
        input logic own_load, input logic chain, input logic [17:0] na);
        if (own_load) begin
            wr_load_n <= 1'b0;
            wr_addr <= a;
            take();
        end
        wr_load_n <= 1'b1;
        wr_addr <= ~a;
        for (int k = 0; k < 4; k++) begin
            wr_data <= d[36*k +: 36];
            sel_n <= s[4*k +: 4];
            // a chained load rides on the last beat of this burst
            if (k == 3 && chain) begin
                wr_load_n <= 1'b0;
                wr_addr <= na;
            end
            take();
        end
        // released: inverted data and selects low, which must not reach the array
        if (!chain) begin
            wr_data <= ~wr_data;
            sel_n <= 4'h0;
        end
    endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clock;
    logic rst_n;
    logic array_hold;
    logic [19:0] rd_addr;
    logic wr_load_n;
    logic [17:0] wr_addr;
    logic [35:0] wr_data;
    logic [3:0] sel_n;
    wire [3:0] ready_all;
    wire [3:0] active_all;
    wire [35:0] rd_all [4];
    wire beat_ready = ready_all[3];
    wire burst_active = active_all[3];
    logic hang;
    logic stall;
    logic [35:0] shadow [4][1024];
    int error_cnt;
    int checks;

    // one device per lane configuration, all fed the same bursts; small depth keeps the arrays light
    for (genvar c = 0; c < 4; c++) begin : g_cfg
        bwl_burst_write #(.CONFIG(2'(c)), .ADDR_W(8)) u_bwl_burst_write (
            .clock(clock), .rst_n(rst_n), .wr_load_n(wr_load_n), .wr_addr(wr_addr[7:0]), .wr_data(wr_data),
            .lane0_write_select_n(sel_n[0]), .lane1_write_select_n(sel_n[1]),
            .lane2_write_select_n(sel_n[2]), .lane3_write_select_n(sel_n[3]),
            .low_nibble_write_select_n(sel_n[0]), .high_nibble_write_select_n(sel_n[1]),
            .array_hold(array_hold), .beat_ready(ready_all[c]), .burst_active(active_all[c]),
            .rd_addr(rd_addr[9:0]), .rd_data(rd_all[c]));
    end
    bwl_ctrl_model u_bwl_ctrl_model (.clock(clock), .wr_load_n(wr_load_n), .wr_addr(wr_addr),
        .wr_data(wr_data), .sel_n(sel_n), .beat_ready(beat_ready), .hang(hang));

    task automatic chk_word(input string nm, input logic [35:0] exp, input logic [35:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_flag(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w, input logic [3:0] s,
        input int lw, input int nl);
        logic [35:0] r;
        r = o;
        for (int b = 0; b < 36; b++)
            if (b / lw < nl && !s[b / lw]) r[b] = w[b];
        return r;
    endfunction
    task automatic do_burst(input logic [17:0] a, input logic [143:0] d, input logic [15:0] s,
        input logic own_load, input logic chain, input logic [17:0] na);
        logic [9:0] idx;
        if (own_load) @(posedge clock);
        u_bwl_ctrl_model.burst(a, d, s, own_load, chain, na);
        for (int k = 0; k < 4; k++) begin
            idx = {a[7:0], k[1:0]};
            shadow[0][idx] = merge(shadow[0][idx], d[36*k +: 36], s[4*k +: 4], bwl_pkg::NIBBLE_W, 2);
            shadow[1][idx] = merge(shadow[1][idx], d[36*k +: 36], s[4*k +: 4], bwl_pkg::BYTE_W, 1);
            shadow[2][idx] = merge(shadow[2][idx], d[36*k +: 36], s[4*k +: 4], bwl_pkg::BYTE_W, 2);
            shadow[3][idx] = merge(shadow[3][idx], d[36*k +: 36], s[4*k +: 4], bwl_pkg::BYTE_W, bwl_pkg::MAX_LANES);
        end
    endtask
    // beats land 1 cycle after they are taken when the array is not held
    task automatic settle();
        int n;
        n = 0;
        @(negedge clock);
        while (burst_active !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) begin
            error_cnt++;
            finish_test();
        end
        repeat (4) @(posedge clock);
    endtask
    task automatic check_addr(input logic [17:0] a);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            rd_addr <= {a, k[1:0]};
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk_word("rd_x8", shadow[0][{a[7:0], k[1:0]}], rd_all[0]);
            chk_word("rd_x9", shadow[1][{a[7:0], k[1:0]}], rd_all[1]);
            chk_word("rd_x18", shadow[2][{a[7:0], k[1:0]}], rd_all[2]);
            chk_word("rd_x36", shadow[3][{a[7:0], k[1:0]}], rd_all[3]);
        end
    endtask
    task automatic t_reset();
        chk_flag("beat_ready", 1'b1, beat_ready);
        chk_flag("burst_active", 1'b0, burst_active);
        $display("test reset done");
    endtask
    task automatic t_full();
        do_burst(18'h10, {36'hF0F0F0F0F, 36'h123456789, 36'hABCDEF012, 36'h555555555}, 16'h0000,
            1'b1, 1'b1, 18'h11);
        do_burst(18'h11, {36'h0F0F0F0F0, 36'hEDCBA9876, 36'h543210FED, 36'hAAAAAAAAA}, 16'h0000,
            1'b0, 1'b0, 18'h0);
        settle();
        check_addr(18'h10);
        check_addr(18'h11);
        $display("test full done");
    endtask
    task automatic t_lanes();
        do_burst(18'h10, {36'h111111111, 36'h222222222, 36'h333333333, 36'h444444444}, 16'h7BDE,
            1'b1, 1'b0, 18'h0);
        do_burst(18'h11, {36'h666666666, 36'h777777777, 36'h888888888, 36'h999999999}, 16'hA50F,
            1'b1, 1'b0, 18'h0);
        settle();
        check_addr(18'h10);
        check_addr(18'h11);
        check_addr(18'h11);
        $display("test lanes done");
    endtask
    task automatic t_stall();
        stall = 1'b0;
        @(posedge clock);
        array_hold <= 1'b1;
        fork
            do_burst(18'h12, {36'hCCCCCCCCC, 36'h333333333, 36'hDEADBEEF0, 36'h0FEEDC0DE}, 16'h0000,
                1'b1, 1'b0, 18'h0);
            begin
                for (int n = 0; n < 20 && !stall; n++) begin
                    @(negedge clock);
                    if (beat_ready === 1'b0) stall = 1'b1;
                end
                repeat (6) @(posedge clock);
                array_hold <= 1'b0;
            end
        join
        chk_flag("stall_seen", 1'b1, stall);
        settle();
        check_addr(18'h12);
        $display("test stall done");
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge hang) begin
        error_cnt++;
        finish_test();
    end
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        array_hold = 1'b0;
        rd_addr = 20'h0;
        error_cnt = 0;
        checks = 0;
        for (int c = 0; c < 4; c++)
            for (int i = 0; i < 1024; i++)
                shadow[c][i] = 36'h0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        t_reset();
        t_full();
        t_lanes();
        t_stall();
        finish_test();
    end
endmodule
